// [verif/upof_host_model.sv]
// host side of the video port: records every byte it accepts and the clock period before it
// assumes the formatter drives the port and the host samples on the rising pixel clock
`timescale 1ns/10ps
`default_nettype none
module upof_host_model (
  // video port from the formatter
  input wire logic       pixel_out_clock,
  input wire logic [7:0] pix_data,
  input wire logic       row_qualifier_short,
  input wire logic       frame_qualifier_short
);
  logic [7:0] got[$];   // accepted bytes, oldest first
  time        per[$];   // pixel clock period ahead of each accepted byte
  time        last_t;   // time of the previous rising clock
  int         idle_cnt; // rising clocks inside a frame with the row low

  initial
  begin
    last_t   = 0;
    idle_cnt = 0;
  end

  // the host cannot stall, so it only samples; bytes count only with both qualifiers up
  always @(posedge pixel_out_clock)
  begin
    if (row_qualifier_short === 1'b1 && frame_qualifier_short === 1'b1)
    begin
      got.push_back(pix_data);
      per.push_back($time - last_t);
    end
    else if (frame_qualifier_short === 1'b1)
      idle_cnt++;
    last_t = $time;
  end
endmodule : upof_host_model
`default_nettype wire

// [verif/upof_top_tb.sv]
// self-checking bench of the pixel output formatter: register port, pixel pairs, host port
// assumes the design files of verilog/ and the host model beside this file
`timescale 1ns/10ps
`include "upof_params.svh"
`default_nettype none
module upof_top_tb;
  logic        ref_clk;      // system clock, 50 ns
  logic        rst;          // synchronous reset
  logic [3:0]  reg_addr;     // register port
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        in_valid;     // pixel pair port
  logic        in_ready;
  logic [7:0]  in_a;
  logic [7:0]  in_b;
  logic [7:0]  in_c;
  logic [7:0]  in_d;
  logic        in_sof;
  logic        in_eol;
  logic        in_eof;
  logic        pclk;         // host video port
  logic [7:0]  pix_data;
  logic        rowq;
  logic        frmq;
  logic [7:0]  exp_q[$];     // expected bytes, oldest first
  int          ci;           // next byte to compare
  int          miscompares;  // mismatches seen
  int          total_checks; // comparisons made
  int          idle0;
  logic [15:0] w;
  // byte order per swap mode (index: Y0, Cb, Y1, Cr), mode bit0 chroma, bit1 luma/chroma
  localparam int ORD [4][4] = '{'{1, 0, 3, 2}, '{3, 0, 1, 2}, '{0, 1, 2, 3}, '{0, 3, 2, 1}};

  upof_top i_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_valid(in_valid),
    .in_ready(in_ready), .in_a(in_a), .in_b(in_b), .in_c(in_c), .in_d(in_d), .in_sof(in_sof),
    .in_eol(in_eol), .in_eof(in_eof), .pixel_out_clock(pclk), .pix_data(pix_data),
    .row_qualifier_short(rowq), .frame_qualifier_short(frmq));

  upof_host_model i_host (.pixel_out_clock(pclk), .pix_data(pix_data),
    .row_qualifier_short(rowq), .frame_qualifier_short(frmq));

  // free running system clock
  always #25 ref_clk = ~ref_clk;

  // one compare for every result; case inequality so unknowns never match
  task automatic chk32(input logic [31:0] e, input logic [31:0] a);
  begin
    total_checks++;
    if (a !== e)
    begin
      miscompares++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, a);
    end
  end
  endtask : chk32

  // register write: one strobe cycle, launched right after an edge
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
  begin
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  end
  endtask : reg_write

  // register read: data stand only in the cycle after the strobe edge
  task automatic reg_read(input logic [3:0] a, input logic [31:0] e);
  begin
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk32(e, reg_rdata);
  end
  endtask : reg_read

  // offer one pair and hold it until an edge that sees in_ready high
  task automatic send_pair(input logic [7:0] a, b, c, d, input logic f, l);
    int   n;
    logic ok;
  begin
    @(posedge ref_clk);
    {in_a, in_b, in_c, in_d} <= {a, b, c, d};
    {in_sof, in_eol, in_eof} <= {f, l, l};
    in_valid <= 1'b1;
    n = 0;
    do
    begin
      #1;
      ok = in_ready;
      @(posedge ref_clk);
      n++;
    end while (ok !== 1'b1 && n < 2000);
    in_valid <= 1'b0;
  end
  endtask : send_pair

  // one YCbCr pair built from a seed, expected in the order of swap mode m
  task automatic send_yuv(input logic [7:0] s, input int m, input logic f, l);
    logic [7:0] v[4];
  begin
    v = '{s + 8'h1, s + 8'h2, s + 8'h3, s + 8'h4};
    for (int k = 0; k < 4; k++)
      exp_q.push_back(v[ORD[m][k]]);
    send_pair(v[0], v[1], v[2], v[3], f, l);
  end
  endtask : send_yuv

  // wait, bounded, for the host to hold all expected bytes, then compare them in order
  task automatic drain();
    int n;
  begin
    n = 0;
    while (i_host.got.size() < exp_q.size() && n < 5000)
    begin
      @(posedge ref_clk);
      n++;
    end
    while (ci < exp_q.size())
    begin
      chk32({24'h0, exp_q[ci]}, {24'h0, i_host.got[ci]});
      ci++;
    end
    // let the idle period after the line end pass before settings change
    repeat (12) @(posedge ref_clk);
  end
  endtask : drain

  // two-byte RGB packing as {odd, even}; chroma swap trades red and blue first
  function automatic logic [15:0] rgb_pack(input int f, input logic [7:0] r0, g, b0,
                                           input logic cs);
    logic [7:0] r;
    logic [7:0] b;
  begin
    r = cs ? b0 : r0;
    b = cs ? r0 : b0;
    case (f)
      1:       rgb_pack = {r[7:3], g[7:5], g[4:2], b[7:3]};
      2:       rgb_pack = {1'b0, r[7:3], g[7:6], g[4:2], b[7:3]};
      3:       rgb_pack = {r[7:4], g[7:4], b[7:4], 4'h0};
      default: rgb_pack = {4'h0, r[7:4], g[7:4], b[7:4]};
    endcase
  end
  endfunction : rgb_pack

  // verdict, reached from the main sequence or the watchdog
  task automatic test_done();
  begin
    $display("checks=%0d mismatches=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask : test_done

  // main sequence
  initial
  begin
    {ref_clk, rst, reg_addr, reg_wdata, reg_wr, reg_rd} = {2'b01, 38'h0};
    {in_valid, in_a, in_b, in_c, in_d, in_sof, in_eol, in_eof} = 36'h0;
    {ci, miscompares, total_checks, idle0} = '0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    // reset values, read back, an unmapped place
    reg_read(`UPOF_REG_CTRL, 32'h0);
    reg_read(`UPOF_REG_CLKDIV, 32'h0201);
    reg_write(4'hC, 32'hFFFF_FFFF);
    reg_read(4'hC, 32'h0);
    reg_write(`UPOF_REG_CTRL, 32'h75);
    reg_read(`UPOF_REG_CTRL, 32'h75);
    // direct path, all four YCbCr orders, with a decimation gap inside each frame;
    // the last order runs under a spare format code, which must act as YCbCr
    for (int m = 0; m < 4; m++)
    begin
      reg_write(`UPOF_REG_CTRL, (32'(m) << 1) | (m == 3 ? 32'h70 : 32'h0));
      idle0 = i_host.idle_cnt;
      send_yuv(8'h10, m, 1'b1, 1'b0);
      repeat (30) @(posedge ref_clk);
      send_yuv(8'h20, m, 1'b0, 1'b1);
      drain();
      chk32(32'h1, 32'(i_host.idle_cnt > idle0));
      chk32(32'h64, 32'(i_host.per[ci - 1]));
    end
    // every RGB packing under every swap setting
    for (int f = 1; f < 5; f++)
      for (int m = 0; m < 4; m++)
      begin
        reg_write(`UPOF_REG_CTRL, (32'(f) << 4) | (32'(m) << 1));
        w = rgb_pack(f, 8'hF1, 8'h5A, 8'h2C, m[0]);
        exp_q.push_back(m[1] ? w[7:0] : w[15:8]);
        exp_q.push_back(m[1] ? w[15:8] : w[7:0]);
        send_pair(8'hF1, 8'h5A, 8'h2C, 8'h00, 1'b1, 1'b1);
        drain();
      end
    // buffered path: a three-pair line at a slower, steady clock
    reg_write(`UPOF_REG_CLKDIV, 32'h0401);
    reg_read(`UPOF_REG_CLKDIV, 32'h0401);
    reg_write(`UPOF_REG_CTRL, 32'h1);
    idle0 = exp_q.size();
    for (int k = 0; k < 3; k++)
      send_yuv(8'(8'h40 + 8 * k), 0, k == 0, k == 2);
    drain();
    for (int k = idle0 + 1; k < exp_q.size(); k++)
      chk32(32'h190, 32'(i_host.per[k]));
    reg_read(`UPOF_REG_STATUS, 32'h0);
    // a line opened by the fill mark with no line end runs dry: zeros and a sticky underrun
    for (int k = 0; k < 200; k++)
      send_pair(8'(k), 8'h80, 8'(k), 8'h80, k == 0, 1'b0);
    repeat (7000) @(posedge ref_clk);
    reg_read(`UPOF_REG_STATUS, 32'h0007_0000);
    send_pair(8'h01, 8'h02, 8'h03, 8'h04, 1'b0, 1'b1);
    repeat (60) @(posedge ref_clk);
    reg_read(`UPOF_REG_STATUS, 32'h0001_0000);
    reg_write(`UPOF_REG_STATUS, 32'h0001_0000);
    reg_read(`UPOF_REG_STATUS, 32'h0);
    test_done();
  end

  // watchdog: the sequence needs well under 20000 cycles
  initial
  begin
    #(50 * 40000);
    miscompares++;
    test_done();
  end
endmodule : upof_top_tb
`default_nettype wire

// [verilog/upof_pack.sv]
// byte packer: one pixel pair (YCbCr) or one pixel (RGB) into up to four output bytes
// assumes inputs are stable in the cycle they are sampled; purely combinational
`timescale 1ns/10ps
`include "upof_params.svh"
`default_nettype none
module upof_pack (
  // settings
  input  wire logic                fmt_code,
  input  wire upof_pkg::upof_fmt_t fmt,
  input  wire logic                cswap,
  input  wire logic                ycswap,
  // pair fields: y0, cb, y1, cr, or r, g, b
  input  wire logic [7:0]          a,
  input  wire logic [7:0]          b,
  input  wire logic [7:0]          c,
  input  wire logic [7:0]          d,
  // packed bytes, byte 0 first
  output logic [31:0]              bytes,
  output logic [2:0]               cnt
);

  logic [7:0] red;   // red after chroma swap
  logic [7:0] blu;   // blue after chroma swap
  logic [7:0] odd;   // first byte of the default packing
  logic [7:0] even;  // second byte of the default packing

  // swaps stay inside one pair, so no byte ever crosses a pair boundary
  always_comb
  begin
    red   = cswap ? c : a;
    blu   = cswap ? a : c;
    odd   = 8'h00;
    even  = 8'h00;
    bytes = 32'h0000_0000;
    cnt   = 3'h2;
    case (fmt)
      upof_pkg::FMT_RGB_FIVE_SIX_FIVE:
      begin
        odd  = {red[7:3], b[7:5]};
        even = {b[4:2], blu[7:3]};
      end
      upof_pkg::FMT_RGB_FIVE_FIVE_FIVE:
      begin
        odd  = {1'b0, red[7:3], b[7:6]};
        even = {b[4:2], blu[7:3]};
      end
      upof_pkg::FMT_RGB_FOUR_TRAILING_PAD:
      begin
        odd  = {red[7:4], b[7:4]};
        even = {blu[7:4], 4'h0};
      end
      upof_pkg::FMT_RGB_FOUR_LEADING_PAD:
      begin
        odd  = {4'h0, red[7:4]};
        even = {b[7:4], blu[7:4]};
      end
      default:
      begin
        odd  = 8'h00;
        even = 8'h00;
      end
    endcase
    if (fmt == upof_pkg::FMT_YUV_422 || fmt_code)
    begin
      // unknown codes fall back to YCbCr; fields a=y0 b=cb c=y1 d=cr
      cnt = 3'h4;
      case ({ycswap, cswap})
        2'b00:   bytes = {c, d, a, b};
        2'b01:   bytes = {c, b, a, d};
        2'b10:   bytes = {d, c, b, a};
        default: bytes = {b, c, d, a};
      endcase
    end
    else
    begin
      bytes = ycswap ? {16'h0000, odd, even} : {16'h0000, even, odd};
    end
  end

endmodule : upof_pack
`default_nettype wire

// [verilog/upof_params.svh]
// constants of the uncompressed pixel output formatter: offsets, fields, resets, sizes
// assumes it is included by its bare name from the testbench and the design modules
`ifndef UPOF_PARAMS_SVH
`define UPOF_PARAMS_SVH

// register offsets on the plain register port
`define UPOF_REG_CTRL     4'h0
`define UPOF_REG_CLKDIV   4'h4
`define UPOF_REG_STATUS   4'h8

// control field positions
`define UPOF_CTRL_BUF     0
`define UPOF_CTRL_CSWAP   1
`define UPOF_CTRL_YCSWAP  2
`define UPOF_CTRL_FMT_LO  4
`define UPOF_CTRL_FMT_HI  6

// status field positions
`define UPOF_STAT_UNDER   16
`define UPOF_STAT_FRAME   17
`define UPOF_STAT_LINE    18

// reset values
`define UPOF_DIV_DIR_RST  8'h01
`define UPOF_DIV_BUF_RST  8'h02

// buffer geometry and the fill level that opens a buffered line early
`define UPOF_BUF_DEPTH    11'h640
`define UPOF_BUF_LAST     11'h63F
`define UPOF_BUF_START    11'h320

`endif

// [verilog/upof_pkg.sv]
// types of the uncompressed pixel output formatter
// assumes the constants header sits beside it
`default_nettype none
package upof_pkg;

  // output pixel formats, as coded in the control register
  typedef enum logic [2:0] {
    FMT_YUV_422,
    FMT_RGB_FIVE_SIX_FIVE,
    FMT_RGB_FIVE_FIVE_FIVE,
    FMT_RGB_FOUR_TRAILING_PAD,
    FMT_RGB_FOUR_LEADING_PAD
  } upof_fmt_t;

  // state of the top module apart from the buffer storage
  typedef struct packed {
    logic        ctrl_buf;   // route through the buffer
    logic        ctrl_cs;    // chroma swap
    logic        ctrl_yc;    // luma/chroma swap
    logic [2:0]  ctrl_fmt;   // output format code
    logic [7:0]  div_dir;    // half period, direct path
    logic [7:0]  div_buf;    // half period, buffered path
    logic        underrun;   // sticky buffer underrun
    logic [31:0] rdata;      // read data register
    logic [31:0] hold;       // pair bytes, byte 0 leaves first
    logic [2:0]  hold_cnt;   // bytes left in the pair
    logic        hold_sof;   // pair opens a frame
    logic        hold_eol;   // pair closes a line
    logic        hold_eof;   // pair closes a frame
    logic        in_ready;   // pair register empty
    logic [10:0] wptr;       // buffer write pointer
    logic [10:0] rptr;       // buffer read pointer
    logic [10:0] level;      // bytes held in the buffer
    logic [10:0] lines;      // line ends held in the buffer
    logic [8:0]  half;       // latched half period
    logic [8:0]  div_cnt;    // divider count
    logic        pclk;       // pixel output clock
    logic [7:0]  dout;       // pixel byte
    logic        rowq;       // row qualifier
    logic        frmq;       // frame qualifier
    logic        in_line;    // a buffered line is open
    logic        gap;        // one idle period after a line end
    logic        gap_eof;    // that line end also ended the frame
  } upof_state_t;

endpackage : upof_pkg
`default_nettype wire

// [verilog/upof_top.sv]
// uncompressed pixel output formatter: register port, pair register, 1600-byte buffer,
// pixel clock divider and the host video port
// assumes the pipeline side runs on ref_clk and the host samples on the rising clock
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/10ps
`include "upof_params.svh"
`default_nettype none
module upof_top (
  // system
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // pixel pairs from the pipeline
  input  wire logic        in_valid,
  output logic             in_ready,
  input  wire logic [7:0]  in_a,
  input  wire logic [7:0]  in_b,
  input  wire logic [7:0]  in_c,
  input  wire logic [7:0]  in_d,
  input  wire logic        in_sof,
  input  wire logic        in_eol,
  input  wire logic        in_eof,
  // host video port
  output logic             pixel_out_clock,
  output logic [7:0]       pix_data,
  output logic             row_qualifier_short,
  output logic             frame_qualifier_short
);

  upof_pkg::upof_state_t s_r;    // registered state
  upof_pkg::upof_state_t s_nxt;  // next state

  logic [10:0] mem [0:1599];     // buffer words: sof, eof, eol, byte
  logic [31:0] pk_bytes;         // packer bytes
  logic [2:0]  pk_cnt;           // packer byte count
  logic        accept;           // pair taken this cycle
  logic        fall;             // pixel clock falls this cycle
  logic        avail;            // a byte is ready for the port
  logic        take_hold;        // pair register gives up a byte
  logic        fifo_wr;          // byte enters the buffer
  logic        fifo_rd;          // byte leaves the buffer
  logic [10:0] hold_word;        // next byte of the pair with flags
  logic [10:0] src_word;         // byte offered to the port
  logic [8:0]  dir_eff;          // direct half period, at least one
  logic [8:0]  half_req;         // half period the settings ask for

  // packer sees the live settings, so they apply from the next pair on
  upof_pack u_pack (
    .fmt_code (s_r.ctrl_fmt > 3'h4),
    .fmt      (upof_pkg::upof_fmt_t'(s_r.ctrl_fmt)),
    .cswap    (s_r.ctrl_cs),
    .ycswap   (s_r.ctrl_yc),
    .a        (in_a),
    .b        (in_b),
    .c        (in_c),
    .d        (in_d),
    .bytes    (pk_bytes),
    .cnt      (pk_cnt)
  );

  // outputs straight from state
  assign reg_rdata             = s_r.rdata;
  assign in_ready              = s_r.in_ready;
  assign pixel_out_clock       = s_r.pclk;
  assign pix_data              = s_r.dout;
  assign row_qualifier_short   = s_r.rowq;
  assign frame_qualifier_short = s_r.frmq;

  // next-state logic
  always_comb
  begin
    s_nxt   = s_r;
    s_nxt.rdata = 32'h0000_0000;  // read data stand one cycle only
    accept  = in_valid && s_r.in_ready;
    fall    = 1'b0;
    // register writes; path and swaps come from settings
    if (reg_wr)
    begin
      if (reg_addr == `UPOF_REG_CTRL)
      begin
        s_nxt.ctrl_buf = reg_wdata[`UPOF_CTRL_BUF];
        s_nxt.ctrl_cs  = reg_wdata[`UPOF_CTRL_CSWAP];
        s_nxt.ctrl_yc  = reg_wdata[`UPOF_CTRL_YCSWAP];
        s_nxt.ctrl_fmt = reg_wdata[`UPOF_CTRL_FMT_HI:`UPOF_CTRL_FMT_LO];
      end
      else if (reg_addr == `UPOF_REG_CLKDIV)
      begin
        s_nxt.div_dir = reg_wdata[7:0];
        s_nxt.div_buf = reg_wdata[15:8];
      end
      else if (reg_addr == `UPOF_REG_STATUS)
      begin
        // write one clears; a new underrun below still wins
        if (reg_wdata[`UPOF_STAT_UNDER])
          s_nxt.underrun = 1'b0;
      end
    end
    // register reads; unmapped offsets read zero
    if (reg_rd)
    begin
      if (reg_addr == `UPOF_REG_CTRL)
        s_nxt.rdata = {25'h0, s_r.ctrl_fmt, 1'b0, s_r.ctrl_yc, s_r.ctrl_cs, s_r.ctrl_buf};
      else if (reg_addr == `UPOF_REG_CLKDIV)
        s_nxt.rdata = {16'h0000, s_r.div_buf, s_r.div_dir};
      else if (reg_addr == `UPOF_REG_STATUS)
        s_nxt.rdata = {13'h0, s_r.in_line, s_r.frmq, s_r.underrun, 5'h00, s_r.level};
      else
        s_nxt.rdata = 32'h0000_0000;
    end
    // buffered lines run slower than the direct rate
    dir_eff  = (s_r.div_dir == 8'h00) ? 9'h001 : {1'b0, s_r.div_dir};
    half_req = dir_eff;
    if (s_r.ctrl_buf)
      half_req = ({1'b0, s_r.div_buf} > dir_eff) ? {1'b0, s_r.div_buf} : dir_eff + 9'h001;
    // divider; the half period is latched only while no row is open
    if (s_r.div_cnt >= s_r.half - 9'h001)
    begin
      s_nxt.div_cnt = 9'h000;
      s_nxt.pclk    = ~s_r.pclk;
      fall          = s_r.pclk;
      if (s_r.pclk && !s_r.rowq)
        s_nxt.half = half_req;
    end
    else
    begin
      s_nxt.div_cnt = s_r.div_cnt + 9'h001;
    end
    // next byte of the pair, with its frame and line marks
    hold_word = {s_r.hold_sof && s_r.hold_cnt == 3'h4 - (s_r.hold_cnt == 3'h2 ? 3'h2 : 3'h0),
                 s_r.hold_eof && s_r.hold_cnt == 3'h1,
                 s_r.hold_eol && s_r.hold_cnt == 3'h1,
                 s_r.hold[7:0]};
    // byte source and its readiness
    if (s_r.ctrl_buf)
    begin
      src_word = mem[s_r.rptr];
      avail    = s_r.level != 11'h000 &&
                 (s_r.in_line || s_r.lines != 11'h000 || s_r.level >= `UPOF_BUF_START);
    end
    else
    begin
      src_word = hold_word;
      avail    = s_r.hold_cnt != 3'h0;
    end
    fifo_wr   = s_r.ctrl_buf && s_r.hold_cnt != 3'h0 && s_r.level < `UPOF_BUF_DEPTH;
    fifo_rd   = 1'b0;
    take_hold = fifo_wr;
    // port side moves on the falling pixel clock, the host samples on the rise
    if (fall)
    begin
      if (s_r.gap)
      begin
        // one idle period closes every line
        s_nxt.rowq = 1'b0;
        s_nxt.gap  = 1'b0;
        if (s_r.gap_eof)
          s_nxt.frmq = 1'b0;
      end
      else if (avail)
      begin
        s_nxt.dout    = src_word[7:0];
        s_nxt.rowq    = 1'b1;
        s_nxt.frmq    = 1'b1;
        s_nxt.gap     = src_word[8] || src_word[9];
        s_nxt.gap_eof = src_word[9];
        s_nxt.in_line = s_r.ctrl_buf && !(src_word[8] || src_word[9]);
        fifo_rd       = s_r.ctrl_buf;
        take_hold     = take_hold || !s_r.ctrl_buf;
      end
      else if (s_r.ctrl_buf && s_r.in_line)
      begin
        // buffer ran dry inside a line: keep the row and clock steady, send zero
        s_nxt.dout     = 8'h00;
        s_nxt.rowq     = 1'b1;
        s_nxt.underrun = 1'b1;
      end
      else
      begin
        // direct bursts leave idle gaps with the row qualifier low
        s_nxt.rowq = 1'b0;
      end
    end
    // buffer pointers and counts
    if (fifo_wr)
      s_nxt.wptr = (s_r.wptr == `UPOF_BUF_LAST) ? 11'h000 : s_r.wptr + 11'h001;
    if (fifo_rd)
      s_nxt.rptr = (s_r.rptr == `UPOF_BUF_LAST) ? 11'h000 : s_r.rptr + 11'h001;
    s_nxt.level = s_r.level + {10'h000, fifo_wr} - {10'h000, fifo_rd};
    s_nxt.lines = s_r.lines + {10'h000, fifo_wr && (hold_word[8] || hold_word[9])}
                            - {10'h000, fifo_rd && (src_word[8] || src_word[9])};
    // pair register drains one byte per take and reloads only when empty
    if (take_hold)
    begin
      s_nxt.hold     = {8'h00, s_r.hold[31:8]};
      s_nxt.hold_cnt = s_r.hold_cnt - 3'h1;
    end
    if (accept)
    begin
      s_nxt.hold     = pk_bytes;
      s_nxt.hold_cnt = pk_cnt;
      s_nxt.hold_sof = in_sof;
      s_nxt.hold_eol = in_eol;
      s_nxt.hold_eof = in_eof;
    end
    s_nxt.in_ready = s_nxt.hold_cnt == 3'h0;
  end

  // state register with synchronous reset
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      s_r          <= '0;
      s_r.div_dir  <= `UPOF_DIV_DIR_RST;
      s_r.div_buf  <= `UPOF_DIV_BUF_RST;
      s_r.half     <= 9'h001;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // buffer storage; not reset, contents are dead until written
  always_ff @(posedge ref_clk)
  begin
    if (fifo_wr)
      mem[s_r.wptr] <= hold_word;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // buffer never holds more than its capacity
  property p_buf_bound;
    s_r.level <= `UPOF_BUF_DEPTH;
  endproperty
  a_buf_bound: assert property (p_buf_bound) else $error("buffer level over capacity");

  // port bytes change only when the pixel clock falls
  property p_dout_on_fall;
    $changed(s_r.dout) |-> $past(s_r.pclk) && !s_r.pclk;
  endproperty
  a_dout_on_fall: assert property (p_dout_on_fall) else $error("byte moved off clock fall");

  // the half period holds while a row stays open
  property p_half_steady;
    s_r.rowq && $past(s_r.rowq) |-> $stable(s_r.half);
  endproperty
  a_half_steady: assert property (p_half_steady) else $error("clock rate moved in a row");

  // a buffered row runs on a latched half period longer than the direct one
  property p_buf_slower;
    s_r.ctrl_buf && s_r.rowq |-> s_r.half > dir_eff;
  endproperty
  a_buf_slower: assert property (p_buf_slower) else $error("buffered clock not slower");

  // default YCbCr order Cb Y0 Cr Y1
  sequence s_take_yuv;
    accept && s_r.ctrl_fmt == 3'h0 && !s_r.ctrl_cs && !s_r.ctrl_yc;
  endsequence
  property p_yuv_default;
    s_take_yuv |=> s_r.hold == {$past(in_c), $past(in_d), $past(in_a), $past(in_b)};
  endproperty
  a_yuv_default: assert property (p_yuv_default) else $error("YCbCr default order wrong");

  // 565 with luma/chroma swap sends the even byte first
  property p_rgb_yc;
    accept && s_r.ctrl_fmt == 3'h1 && !s_r.ctrl_cs && s_r.ctrl_yc
      |=> s_r.hold[7:0] == {$past(in_b[4:2]), $past(in_c[7:3])};
  endproperty
  a_rgb_yc: assert property (p_rgb_yc) else $error("RGB byte swap wrong");

  // 565 with chroma swap puts blue in the red field
  property p_rgb_cs;
    accept && s_r.ctrl_fmt == 3'h1 && s_r.ctrl_cs && !s_r.ctrl_yc
      |=> s_r.hold[15:0] == {$past(in_b[4:2]), $past(in_a[7:3]),
                             $past(in_c[7:3]), $past(in_b[7:5])};
  endproperty
  a_rgb_cs: assert property (p_rgb_cs) else $error("RGB red/blue swap wrong");

  // 555 default packing
  property p_rgb_555;
    accept && s_r.ctrl_fmt == 3'h2 && !s_r.ctrl_cs && !s_r.ctrl_yc
      |=> s_r.hold[15:0] == {$past(in_b[4:2]), $past(in_c[7:3]), 1'b0,
                             $past(in_a[7:3]), $past(in_b[7:6])};
  endproperty
  a_rgb_555: assert property (p_rgb_555) else $error("555 packing wrong");

  // leading-pad 444 default packing
  property p_rgb_x444;
    accept && s_r.ctrl_fmt == 3'h4 && !s_r.ctrl_cs && !s_r.ctrl_yc
      |=> s_r.hold[15:0] == {$past(in_b[7:4]), $past(in_c[7:4]), 4'h0, $past(in_a[7:4])};
  endproperty
  a_rgb_x444: assert property (p_rgb_x444) else $error("leading-pad 444 wrong");

  // a pair is only taken into an empty pair register
  property p_pair_whole;
    accept |-> s_r.hold_cnt == 3'h0 ##1 s_r.hold_cnt == $past(pk_cnt);
  endproperty
  a_pair_whole: assert property (p_pair_whole) else $error("pair overlapped");

  // the row qualifier never stands without the frame qualifier
  property p_row_in_frame;
    s_r.rowq |-> s_r.frmq;
  endproperty
  a_row_in_frame: assert property (p_row_in_frame) else $error("row outside frame");

endmodule : upof_top
`default_nettype wire
